// File: tb/test_acs_sequencer.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module test_acs_sequencer;
    import acs_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [7:0]  trig = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [1:0]  r;
    logic        rise;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        bready = 1'b0;
    logic        arv = 1'b0;
    logic        rready = 1'b0;
    logic        awr, wrdy, bv, arr, rv, busy, samp;
    logic [1:0]  bresp, rresp;
    acs_sel_s    sel;
    int          error_cnt = 0;
    int          compares = 0;
    int          n;
    int          blen = 0;
    int          last_len = 0;

    acs_sequencer dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .trig_in(trig), .core_result(10'h2A5),
        .core_sel(sel), .core_sample(samp), .core_busy(busy),
        .core_rise(rise));

    always #20 clk = ~clk;

    // Busy length in clocks, judged mid-cycle where busy is settled
    always @(negedge clk) begin
        if (busy === 1'b1) begin
            blen <= blen + 1;
        end else if (blen != 0) begin
            last_len <= blen;
            blen <= 0;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task tick;
        @(posedge clk);
        #1;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    // Handshakes judged 1 ns after the edge before the one that takes them
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        awaddr <= a; wdata <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        hb = 1'b0;
        while (!hb) begin
            #1;
            ha = awv && awr; hw = wv && wrdy; hb = bv;
            r = bresp;
            @(posedge clk);
            if (ha) awv <= 1'b0;
            if (hw) wv <= 1'b0;
            if (hb) bready <= 1'b0;
        end
        #1;
    endtask
    task rd(input logic [7:0] a);
        logic ha, h;
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        h = 1'b0;
        while (!h) begin
            #1;
            ha = arv && arr; h = rv; d = rdata; r = rresp;
            @(posedge clk);
            if (ha) arv <= 1'b0;
            if (h) rready <= 1'b0;
        end
        #1;
    endtask
    task rc(input string s, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(s, e, d);
    endtask
    // Busy may already be high on entry; the monitor saw it rise
    task conv(output int len);
        int i;
        for (i = 0; i < 3000 && busy !== 1'b1; i++) tick;
        for (i = 0; i < 3000 && busy === 1'b1; i++) tick;
        tick;
        len = last_len;
    endtask
    task to_samp;
        int i;
        for (i = 0; i < 3000 && samp !== 1'b1; i++) tick;
        tick;
    endtask
    task final_report;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (3) tick;
        nrst <= 1'b1;
        tick;
        rc("ctrl_a", ACS_CTRL_A_OFS, 32'h70);
        rc("ctrl_b", ACS_CTRL_B_OFS, 32'h80);
        rc("stat", ACS_STAT_OFS, 32'h10);
        rd(8'h20);
        chk("unmapped", 32'h2, {30'h0, r});
        wr(8'h20, 32'h0);
        chk("wr_unmapped", 32'h2, {30'h0, r});
        wr(ACS_SEL_OFS, 32'h5);
        chk("wr_okay", 32'h0, {30'h0, r});
        chk("sel_off", 32'h0, {28'h0, sel});
        wr(ACS_CTRL_B_OFS, 32'h0);
        wr(ACS_CTRL_A_OFS, 32'h1);
        wr(ACS_CTRL_A_OFS, 32'h3);
        rc("start_rd", ACS_CTRL_A_OFS, 32'h3);
        conv(n);
        chk("first_len", 32'd50, n);
        rc("result", ACS_RES_OFS, 32'h2A5);
        rc("flag", ACS_CTRL_A_OFS, 32'h9);
        wr(ACS_CTRL_A_OFS, 32'hB);
        conv(n);
        chk("norm_len", 32'd26, n);
        wr(ACS_CTRL_A_OFS, 32'h3);
        wr(ACS_SEL_OFS, 32'hA);
        chk("sel_lock", 32'h5, {28'h0, sel});
        conv(n);
        chk("sel_new", 32'hA, {28'h0, sel});
        wr(ACS_CTRL_A_OFS, 32'h13);
        conv(n);
        chk("ps1_len", 32'd52, n);
        wr(ACS_CTRL_B_OFS, 32'h1);
        wr(ACS_SEL_OFS, 32'h3);
        wr(ACS_CTRL_A_OFS, 32'h5);
        trig <= 8'h02;
        conv(n);
        chk("auto_len", 32'd27, n);
        chk("sel_auto", 32'h3, {28'h0, sel});
        trig <= 8'h00;
        repeat (5) tick;
        trig <= 8'h02;
        repeat (8) tick;
        trig <= 8'h00;
        repeat (3) tick;
        trig <= 8'h02;
        conv(n);
        repeat (10) tick;
        chk("no_retrig", 32'h0, {31'h0, busy});
        wr(ACS_CTRL_B_OFS, 32'h0);
        wr(ACS_CTRL_A_OFS, 32'h7);
        to_samp;
        to_samp;
        n = 1;
        while (samp !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        chk("free_len", 32'd28, n);
        rc("free_start", ACS_CTRL_A_OFS, 32'hF);
        tick;
        r[0] = rise;
        tick;
        r[1] = rise;
        chk("rise_alt", 32'h1, {31'h0, r[0] ^ r[1]});
        wr(ACS_CTRL_A_OFS, 32'h0);
        chk("off_busy", 32'h0, {31'h0, busy});
        chk("rise_off", 32'h0, {31'h0, rise});
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule

// File: verilog/acs_pkg.sv
// Constants, types and layout of the converter sequencer
// Function
// RULE_01: Software clears the power-reduce bit so the converter is supplied and clocked.
// RULE_02: Writing one to start launches a conversion; hardware clears it when done.
// RULE_03: A channel change mid-conversion applies only after the running conversion.
// RULE_04: With auto-trigger, a selected trigger rising edge resets prescaler and starts conversion.
// RULE_05: Trigger still high at completion starts nothing; edges during conversion are ignored.
// RULE_06: A source flag must clear before its next event can trigger again.
// RULE_07: Complete flag as trigger free-runs, regardless of the flag being cleared.
// RULE_08: Software starts the first free-running conversion by writing the start bit.
// RULE_09: Start bit still works with auto-trigger and reads one during any conversion.
// RULE_10: Prescaler divides by selected ratio, runs while enabled, held reset otherwise.
// RULE_11: A software start begins at the next converter clock rising edge.
// RULE_12: Normal conversion takes 13 converter cycles; first after enable takes 25.
// RULE_13: Sample-and-hold at 1.5 cycles normally, 13.5 cycles for the first.
// RULE_14: Completion writes result, sets flag and clears start in single mode.
// RULE_15: Auto-triggered: sample at 2 cycles after trigger, conversion 13.5 cycles.
// RULE_16: Free-running: restarts at once, sample at 2.5 cycles, 14 cycles each.
// RULE_17: Selection buffer copies to active selection until a conversion starts, then locks.
// RULE_18: Copying resumes in the last converter cycle before completion.
// RULE_19: Software waits one converter cycle after start before changing selection.
// RULE_20: With auto-trigger, software changes selection only in the safe windows.
// RULE_21: Free-run channel change after first result affects the conversion after next.
// RULE_22: Reference is supply or internal; discard first result after switching.
// RULE_23: Selections reach the converter only while the converter is enabled.
// RULE_24: Trigger source chosen by three-bit field, bits 2 to 0 of control B.
// RULE_25: Selected trigger is synchronised and edge-detected before starting.
// RULE_26: Prescaler ratio is a field defaulting to the largest ratio.
package acs_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ACS_CTRL_A_OFS = 8'h00;
    localparam logic [7:0] ACS_CTRL_B_OFS = 8'h04;
    localparam logic [7:0] ACS_SEL_OFS    = 8'h08;
    localparam logic [7:0] ACS_STAT_OFS   = 8'h0C;
    localparam logic [7:0] ACS_RES_OFS    = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CA_EN_BIT    = 0;
    localparam int CA_START_BIT = 1;
    localparam int CA_AUTO_BIT  = 2;
    localparam int CA_FLAG_BIT  = 3;
    localparam int CA_PS_LSB    = 4;
    localparam int CB_TS_LSB    = 0;
    localparam int CB_PRR_BIT   = 7;
    localparam int SEL_CH_LSB   = 0;
    localparam int SEL_REF_BIT  = 3;
    localparam int ST_SEL_LSB   = 0;
    localparam int ST_FIRST_BIT = 4;
    localparam int ST_BUSY_BIT  = 5;

    // ------------------------------------------------------------
    // Reset values and the free-running trigger source
    // ------------------------------------------------------------
    localparam logic [2:0] PS_RST  = 3'h7;
    localparam logic [2:0] TS_RST  = 3'h0;
    localparam logic       PRR_RST = 1'b1;
    localparam logic [2:0] TS_FREE = 3'h0;

    // ------------------------------------------------------------
    // Timing in converter half cycles
    // ------------------------------------------------------------
    localparam logic [5:0] HC_NORM_SH  = 6'h03;
    localparam logic [5:0] HC_NORM_LEN = 6'h1A;
    localparam logic [5:0] HC_FRST_SH  = 6'h1B;
    localparam logic [5:0] HC_FRST_LEN = 6'h32;
    localparam logic [5:0] HC_AUTO_SH  = 6'h04;
    localparam logic [5:0] HC_AUTO_LEN = 6'h1B;
    localparam logic [5:0] HC_FREE_SH  = 6'h05;
    localparam logic [5:0] HC_FREE_LEN = 6'h1C;
    localparam logic [5:0] HC_LAST     = 6'h02;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_CONV = 1'b1
    } acs_state_e;

    typedef struct packed {
        logic       ref_sel;
        logic [2:0] channel;
    } acs_sel_s;

    typedef struct packed {
        logic [5:0] sh;
        logic [5:0] len;
    } acs_timing_s;

endpackage

// File: verilog/acs_prescaler.sv
// Converter clock prescaler giving rising and falling tick enables
`timescale 1ns/1ps
module acs_prescaler
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Control
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic [2:0] ps,
    // Ticks
    output logic            rise_tick,
    output logic            fall_tick
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] last;

    // Divide by 2 << ps
    assign last = 8'((9'h002 << ps) - 9'h001);

    always_comb begin
        if (!run || restart) begin
            cnt_nxt = 8'h00; // RULE_10 RULE_04
        end else if (cnt_r >= last) begin
            // A lower ratio mid-count must not run on to the wrap
            cnt_nxt = 8'h00;
        end else begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign rise_tick = run && !restart && (cnt_r == last); // RULE_10
    assign fall_tick = run && !restart && (cnt_r == (last >> 1));

    a_held_idle: // RULE_10
    assert property (@(posedge clk) disable iff (!nrst)
        !run |=> (cnt_r == 8'h00) && !rise_tick)
    else $error("prescaler ran while disabled");

    a_tick_apart: // RULE_10
    assert property (@(posedge clk) disable iff (!nrst)
        rise_tick |=> !rise_tick)
    else $error("rising ticks back to back");

endmodule

// File: verilog/acs_sequencer.sv
// Conversion sequencer with AXI4-Lite register slave
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module acs_sequencer
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Trigger sources, bit 0 unused
    input  wire logic [7:0]  trig_in,
    // Analog core
    input  wire logic [9:0]  core_result,
    output acs_sel_s         core_sel,
    output logic             core_sample,
    output logic             core_busy,
    output logic             core_rise
);

    // ------------------------------------------------------------
    // Bus slave and configuration
    // ------------------------------------------------------------
    logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
    logic [7:0]  waddr_r, waddr_nxt;
    logic [7:0]  wbyte_r, wbyte_nxt;
    logic        wstb_r, wstb_nxt;
    logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        en_r, en_nxt, auto_r, auto_nxt, prr_r, prr_nxt;
    logic [2:0]  ps_r, ps_nxt, ts_r, ts_nxt;
    acs_sel_s    buf_r, buf_nxt;
    logic        do_write, wr_a, wr_start, wr_flag_clr;

    // Conversion group
    acs_state_e  state_r, state_nxt;
    logic [5:0]  hc_r, hc_nxt;
    acs_timing_s tm_r, tm_nxt;
    logic        start_r, start_nxt, flag_r, flag_nxt;
    logic        first_r, first_nxt, samp_r, samp_nxt;
    logic [9:0]  res_r, res_nxt;
    acs_sel_s    act_r, act_nxt;
    logic [2:0]  tsync_r, tsync_nxt;
    logic        conv_on, half, rise, fall, done, locked;
    logic        free_mode, auto_go, soft_go, trig_edge, pre_restart;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[7:2] == ACS_CTRL_A_OFS[7:2]) ||
                 (a[7:2] == ACS_CTRL_B_OFS[7:2]) ||
                 (a[7:2] == ACS_SEL_OFS[7:2])    ||
                 (a[7:2] == ACS_STAT_OFS[7:2])   ||
                 (a[7:2] == ACS_RES_OFS[7:2]);
    endfunction

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    // Both halves held before the register changes
    assign do_write    = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_a        = do_write && wstb_r &&
                         (waddr_r[7:2] == ACS_CTRL_A_OFS[7:2]);
    assign wr_start    = wr_a && wbyte_r[CA_START_BIT];
    assign wr_flag_clr = wr_a && wbyte_r[CA_FLAG_BIT];

    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt  = w_hold_r;
        waddr_nxt   = waddr_r;
        wbyte_nxt   = wbyte_r;
        wstb_nxt    = wstb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        en_nxt      = en_r;
        auto_nxt    = auto_r;
        ps_nxt      = ps_r;
        ts_nxt      = ts_r;
        prr_nxt     = prr_r;
        buf_nxt     = buf_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_nxt = 1'b1;
            waddr_nxt   = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_nxt = 1'b1;
            wbyte_nxt  = s_axi_wdata[7:0];
            wstb_nxt   = s_axi_wstrb[0];
        end
        if (do_write) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = mapped(waddr_r) ? 2'h0 : 2'h2;
            if (wstb_r) begin
                case (waddr_r[7:2])
                    ACS_CTRL_A_OFS[7:2]: begin
                        en_nxt   = wbyte_r[CA_EN_BIT];
                        auto_nxt = wbyte_r[CA_AUTO_BIT];
                        ps_nxt   = wbyte_r[CA_PS_LSB +: 3]; // RULE_26
                    end
                    ACS_CTRL_B_OFS[7:2]: begin
                        ts_nxt  = wbyte_r[CB_TS_LSB +: 3]; // RULE_24
                        prr_nxt = wbyte_r[CB_PRR_BIT];
                    end
                    ACS_SEL_OFS[7:2]: begin
                        // Buffer writable at any time
                        buf_nxt.channel = wbyte_r[SEL_CH_LSB +: 3]; // RULE_17
                        buf_nxt.ref_sel = wbyte_r[SEL_REF_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
            rdata_nxt  = 32'h0000_0000;
            case (s_axi_araddr[7:2])
                ACS_CTRL_A_OFS[7:2]: begin
                    rdata_nxt[CA_EN_BIT]     = en_r;
                    rdata_nxt[CA_START_BIT]  = start_r; // RULE_09
                    rdata_nxt[CA_AUTO_BIT]   = auto_r;
                    rdata_nxt[CA_FLAG_BIT]   = flag_r;
                    rdata_nxt[CA_PS_LSB +: 3] = ps_r;
                end
                ACS_CTRL_B_OFS[7:2]: begin
                    rdata_nxt[CB_TS_LSB +: 3] = ts_r;
                    rdata_nxt[CB_PRR_BIT]     = prr_r;
                end
                ACS_SEL_OFS[7:2]: begin
                    rdata_nxt[3:0] = buf_r;
                end
                ACS_STAT_OFS[7:2]: begin
                    rdata_nxt[ST_SEL_LSB +: 4] = act_r;
                    rdata_nxt[ST_FIRST_BIT]    = first_r;
                    rdata_nxt[ST_BUSY_BIT]     = (state_r == ST_CONV);
                end
                ACS_RES_OFS[7:2]: begin
                    rdata_nxt[9:0] = res_r;
                end
                default: begin
                end
            endcase
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wbyte_r   <= 8'h00;
            wstb_r    <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= 2'h0;
            rvalid_r  <= 1'b0;
            rresp_r   <= 2'h0;
            rdata_r   <= 32'h0000_0000;
            en_r      <= 1'b0;
            auto_r    <= 1'b0;
            ps_r      <= PS_RST; // RULE_26
            ts_r      <= TS_RST;
            prr_r     <= PRR_RST;
            buf_r     <= '0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            waddr_r   <= waddr_nxt;
            wbyte_r   <= wbyte_nxt;
            wstb_r    <= wstb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            en_r      <= en_nxt;
            auto_r    <= auto_nxt;
            ps_r      <= ps_nxt;
            ts_r      <= ts_nxt;
            prr_r     <= prr_nxt;
            buf_r     <= buf_nxt;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencing
    // ------------------------------------------------------------
    // Power-reduce gates the whole converter, enable or not
    assign conv_on   = en_r && !prr_r; // RULE_01 RULE_10
    assign half      = rise || fall;
    assign free_mode = auto_r && (ts_r == TS_FREE);
    assign trig_edge = tsync_r[1] && !tsync_r[2]; // RULE_25 RULE_06
    // Edges while busy fall on the idle-only start path
    assign auto_go   = conv_on && auto_r && !free_mode && trig_edge &&
                       (state_r == ST_IDLE); // RULE_04 RULE_05
    assign soft_go   = conv_on && start_r && rise &&
                       (state_r == ST_IDLE) && !auto_go; // RULE_11
    assign pre_restart = auto_go;
    assign done      = (state_r == ST_CONV) && half &&
                       (hc_r + 6'h01 == tm_r.len);
    assign locked    = (state_r == ST_CONV) &&
                       (hc_r < tm_r.len - HC_LAST); // RULE_18

    acs_prescaler u_pre (
        .clk       (clk),
        .nrst      (nrst),
        .run       (conv_on),
        .restart   (pre_restart),
        .ps        (ps_r),
        .rise_tick (rise),
        .fall_tick (fall)
    );

    always_comb begin
        state_nxt = state_r;
        hc_nxt    = hc_r;
        tm_nxt    = tm_r;
        start_nxt = start_r;
        flag_nxt  = flag_r;
        first_nxt = first_r;
        res_nxt   = res_r;
        act_nxt   = act_r;
        samp_nxt  = 1'b0;
        // Synchroniser then edge register
        tsync_nxt = {tsync_r[1:0], trig_in[ts_r]}; // RULE_25
        if (wr_start && conv_on) begin
            start_nxt = 1'b1; // RULE_02 RULE_09
        end
        if (wr_flag_clr) begin
            flag_nxt = 1'b0;
        end
        // Only copy while enabled and not locked
        if (conv_on && !locked) begin
            act_nxt = buf_r; // RULE_17 RULE_23 RULE_03 RULE_21
        end
        case (state_r)
            ST_IDLE: begin
                if (auto_go) begin
                    state_nxt = ST_CONV;
                    hc_nxt    = 6'h00;
                    start_nxt = 1'b1; // RULE_09
                    tm_nxt.sh  = first_r ? HC_FRST_SH  : HC_AUTO_SH;
                    tm_nxt.len = first_r ? HC_FRST_LEN : HC_AUTO_LEN; // RULE_15
                end else if (soft_go) begin
                    state_nxt = ST_CONV;
                    hc_nxt    = 6'h00;
                    tm_nxt.sh  = first_r ? HC_FRST_SH  : HC_NORM_SH; // RULE_13
                    tm_nxt.len = first_r ? HC_FRST_LEN : HC_NORM_LEN; // RULE_12
                end
            end
            ST_CONV: begin
                if (half) begin
                    hc_nxt   = hc_r + 6'h01;
                    samp_nxt = (hc_r + 6'h01 == tm_r.sh); // RULE_13
                end
                if (done) begin
                    res_nxt   = core_result; // RULE_14
                    flag_nxt  = 1'b1; // Set wins over a same-cycle clear
                    first_nxt = 1'b0;
                    if (free_mode) begin
                        hc_nxt = 6'h00; // RULE_07 RULE_16
                        tm_nxt = '{HC_FREE_SH, HC_FREE_LEN};
                    end else begin
                        state_nxt = ST_IDLE;
                        start_nxt = 1'b0; // RULE_14 RULE_02
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Disable aborts and re-arms the long first conversion
        if (!conv_on) begin
            state_nxt = ST_IDLE;
            start_nxt = 1'b0;
            first_nxt = 1'b1; // RULE_12
            samp_nxt  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            hc_r    <= 6'h00;
            tm_r    <= '{HC_NORM_SH, HC_NORM_LEN};
            start_r <= 1'b0;
            flag_r  <= 1'b0;
            first_r <= 1'b1;
            samp_r  <= 1'b0;
            res_r   <= 10'h000;
            act_r   <= '0;
            tsync_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            hc_r    <= hc_nxt;
            tm_r    <= tm_nxt;
            start_r <= start_nxt;
            flag_r  <= flag_nxt;
            first_r <= first_nxt;
            samp_r  <= samp_nxt;
            res_r   <= res_nxt;
            act_r   <= act_nxt;
            tsync_r <= tsync_nxt;
        end
    end

    assign core_sel    = act_r;
    assign core_sample = samp_r;
    assign core_busy   = (state_r == ST_CONV);
    assign core_rise   = rise;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_busy_start: // RULE_09
    assert property (@(posedge clk) disable iff (!nrst)
        (state_r == ST_CONV) |-> start_r)
    else $error("start bit low during conversion");

    a_single_end: // RULE_14
    assert property (@(posedge clk) disable iff (!nrst)
        (done && !free_mode && conv_on) |=>
        !start_r && flag_r && (state_r == ST_IDLE))
    else $error("single completion did not clear start");

    a_free_rerun: // RULE_07
    assert property (@(posedge clk) disable iff (!nrst)
        (done && free_mode && conv_on) |=>
        (state_r == ST_CONV) && (tm_r.len == HC_FREE_LEN) && (hc_r == 6'h00))
    else $error("free running did not restart");

    a_first_long: // RULE_12
    assert property (@(posedge clk) disable iff (!nrst)
        (done && first_r) |-> (tm_r.len == HC_FRST_LEN))
    else $error("first conversion length wrong");

    a_sel_locked: // RULE_03
    assert property (@(posedge clk) disable iff (!nrst)
        ($past(locked) && locked) |-> $stable(act_r))
    else $error("selection changed while locked");

    a_sel_gated: // RULE_23
    assert property (@(posedge clk) disable iff (!nrst)
        !conv_on |=> $stable(act_r))
    else $error("selection applied while disabled");

    a_auto_start: // RULE_04
    assert property (@(posedge clk) disable iff (!nrst)
        auto_go |=> (state_r == ST_CONV) && (hc_r == 6'h00) && start_r)
    else $error("trigger edge did not start conversion");

    a_edge_ignored: // RULE_05
    assert property (@(posedge clk) disable iff (!nrst)
        ((state_r == ST_CONV) && !half && conv_on) |=>
        (hc_r == $past(hc_r)) && (state_r == ST_CONV))
    else $error("conversion disturbed between converter edges");

    a_sample_point: // RULE_13
    assert property (@(posedge clk) disable iff (!nrst)
        samp_r |-> ($past(hc_r) + 6'h01 == tm_r.sh))
    else $error("sample pulse off its point");

endmodule
